// ===== ddrm_lane_mapper.sv
`timescale 1ns/1ps
// Functional notes
// [R1] first byte is A, second is B
// [R2] memory space words pass through unreordered
// [R3] host little-endian: low bits in byte A
// [R4] read delivers a whole word per bus cycle; the code takes two link_clk cycles per word, one byte per rising edge
// [R5] register read: word[15:8] while strobe high
// [R6] register read: word[7:0] while strobe low
// [R7] byte bit n sits on lane n
// [R8] space select bit: 0 memory, 1 register
// [R9] host register write: upper byte first
`include "ddrm_params.svh"
module ddrm_lane_mapper (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ddrm_pkg::ddrm_word_t rd_word,
  input wire logic rd_valid,
  output logic rd_ready,
  output ddrm_pkg::ddrm_word_t wr_word_q,
  output logic wr_space_q,
  output logic wr_valid_q,
  output logic link_read_q,
  output logic link_space_q,
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic read_cycle,
  input wire logic space_select_bit,
  input wire ddrm_pkg::ddrm_byte_t dq_i,
  output ddrm_pkg::ddrm_byte_t dq_o,
  output logic dq_oe,
  input wire logic read_write_data_strobe_i,
  output logic read_write_data_strobe_o,
  output logic read_write_data_strobe_oe
);
  import ddrm_pkg::*;

  // link side: one link_clk edge per data phase
  ddrm_word_t fifo_data; // head word, registered in the fifo
  logic fifo_valid; // head word present
  logic fifo_take; // serialiser consumes the head word
  ddrm_state_t state_q; // current phase on the pins
  ddrm_word_t word_q; // word being put out
  logic reading; // read transaction selected
  logic writing; // write transaction selected
  logic start; // a new word begins this edge

  // read words cross from ref_clk to link_clk through the fifo
  ddrm_fifo #(
    .W(`DDRM_WORD_W),
    .D(`DDRM_FIFO_D)
  ) u_fifo (
    .wr_clk(ref_clk),
    .rd_clk(link_clk),
    .rst(rst),
    .in_data(rd_word),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .out_data(fifo_data),
    .out_ready(fifo_take),
    .out_valid(fifo_valid)
  );

  // transaction kind decoded from the link pins
  assign reading = ~sel_n & read_cycle;
  assign writing = ~sel_n & ~read_cycle;
  // a new word may start unless byte B of the last one is still due
  // the fifo head is only taken on a byte A edge, so words never interleave
  assign start = reading & fifo_valid & (state_q != ST_A);
  assign fifo_take = start;

  // read serialiser: byte A with strobe high, then byte B with strobe low
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      word_q <= '0;
      dq_o <= '0;
      read_write_data_strobe_o <= 1'b0;
    end else begin
      case (state_q)
        ST_A: begin
          // second phase always follows, so a word never splits
          state_q <= ST_B; // R4
          dq_o <= word_q[`DDRM_B_HI:`DDRM_B_LO]; // R6
          read_write_data_strobe_o <= 1'b0; // R6
        end
        ST_IDLE, ST_B: begin
          if (start) begin
            // same placement in both spaces: memory words come back as written
            state_q <= ST_A;
            word_q <= fifo_data; // R2
            dq_o <= fifo_data[`DDRM_A_HI:`DDRM_A_LO]; // R5 R7
            read_write_data_strobe_o <= 1'b1; // R5
          end else begin
            // strobe parks low between words
            state_q <= ST_IDLE;
            read_write_data_strobe_o <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          read_write_data_strobe_o <= 1'b0;
        end
      endcase
    end
  end

  // pin enables: device owns the strobe for the whole read
  // the host may park its clock and then deselect, so deselect clears both enables at once
  // without it the strobe would stay driven until the next frame's first edge
  always_ff @(posedge link_clk or posedge rst or posedge sel_n) begin
    if (rst) begin
      dq_oe <= 1'b0;
      read_write_data_strobe_oe <= 1'b0;
    end else if (sel_n) begin
      // deselected: lanes and strobe go back to the host
      dq_oe <= 1'b0;
      read_write_data_strobe_oe <= 1'b0;
    end else begin
      dq_oe <= reading & (start | (state_q == ST_A));
      read_write_data_strobe_oe <= reading;
    end
  end

  // write capture: alternate A and B phases while selected
  logic phase_q; // which byte comes next
  ddrm_byte_t byte_a_q; // held byte A
  ddrm_word_t wr_hold_q; // assembled word, stable for the other domain
  logic wr_hold_space_q; // space of the held word
  logic wr_tgl_q; // flips once per assembled word
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      phase_q <= `DDRM_PH_A;
      byte_a_q <= '0;
      wr_hold_q <= '0;
      wr_hold_space_q <= 1'b0;
      wr_tgl_q <= 1'b0;
    end else if (!writing) begin
      // a link_clk edge with no write selected realigns so the next transfer starts on byte A
      phase_q <= `DDRM_PH_A;
    end else if (phase_q == `DDRM_PH_A) begin
      byte_a_q <= dq_i; // R1
      phase_q <= `DDRM_PH_B;
    end else begin
      // A lands in the upper half; a little-endian host sees its own order back
      wr_hold_q <= {byte_a_q, dq_i}; // R1 R3 R9
      wr_hold_space_q <= space_select_bit; // R8
      wr_tgl_q <= ~wr_tgl_q;
      phase_q <= `DDRM_PH_A;
    end
  end

  // ref side: toggle through two flops, then edge detect
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= wr_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end
  // held word is stable for several cycles once the toggle is seen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_word_q <= '0;
      wr_space_q <= 1'b0;
      wr_valid_q <= 1'b0;
    end else begin
      wr_valid_q <= tgl_s2_q ^ tgl_s3_q;
      if (tgl_s2_q ^ tgl_s3_q) begin
        wr_word_q <= wr_hold_q;
        wr_space_q <= wr_hold_space_q; // R8
      end
    end
  end

  // transaction levels for the core, two flops each
  logic rd_s1_q, sp_s1_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_s1_q <= 1'b0;
      sp_s1_q <= 1'b0;
      link_read_q <= 1'b0;
      link_space_q <= 1'b0;
    end else begin
      rd_s1_q <= reading;
      sp_s1_q <= space_select_bit;
      link_read_q <= rd_s1_q;
      link_space_q <= sp_s1_q; // R8
    end
  end

  // checks on the link side
  a_word_per_cycle: assert property (@(posedge link_clk) disable iff (rst) // R4
    start |=> (state_q == ST_A) ##1 (state_q == ST_B)) else $error("word not sent in two phases");
  a_byte_a_upper: assert property (@(posedge link_clk) disable iff (rst) // R5
    (state_q == ST_A) |-> (dq_o == word_q[`DDRM_A_HI:`DDRM_A_LO]) && read_write_data_strobe_o)
    else $error("byte A wrong");
  a_byte_b_lower: assert property (@(posedge link_clk) disable iff (rst) // R6
    (state_q == ST_A) |=> (dq_o == $past(word_q[`DDRM_B_HI:`DDRM_B_LO])) && !read_write_data_strobe_o)
    else $error("byte B wrong");
  a_lane_bit_order: assert property (@(posedge link_clk) disable iff (rst) // R7
    (state_q == ST_B) |-> (dq_o[`DDRM_B_HI] == word_q[`DDRM_B_HI]) && (dq_o[`DDRM_B_LO] == word_q[`DDRM_B_LO]))
    else $error("lane order wrong");
  a_idle_no_drive: assert property (@(posedge link_clk) disable iff (rst) // R4
    !reading |=> !dq_oe && !read_write_data_strobe_oe) else $error("lanes driven outside a read");
  a_mem_passthru: assert property (@(posedge link_clk) disable iff (rst) // R2
    start |=> (word_q == $past(fifo_data))) else $error("word altered");
  a_write_pairing: assert property (@(posedge link_clk) disable iff (rst) // R1
    (writing && phase_q == `DDRM_PH_B) |=> (wr_hold_q == {$past(byte_a_q), $past(dq_i)})) else $error("pair wrong");
  a_space_capture: assert property (@(posedge link_clk) disable iff (rst) // R8
    $changed(wr_tgl_q) |-> (wr_hold_space_q == $past(space_select_bit))) else $error("space lost");
  // checks on the core side; the link clock may be parked while deselected
  a_write_pulse: assert property (@(posedge ref_clk) disable iff (rst) // R1
    wr_valid_q |=> !wr_valid_q) else $error("write pulse too long");
  a_oe_on_deselect: assert property (@(posedge ref_clk) disable iff (rst) // R4
    sel_n |-> !dq_oe && !read_write_data_strobe_oe) else $error("lanes driven while deselected");
  // scenarios worth seeing
  c_read_back_to_back: cover property (@(posedge link_clk) disable iff (rst)
    (state_q == ST_A) ##1 (state_q == ST_B) ##1 (state_q == ST_A));
  c_register_read: cover property (@(posedge link_clk) disable iff (rst) start && space_select_bit);
  c_memory_read: cover property (@(posedge link_clk) disable iff (rst) start && !space_select_bit);
  c_register_write: cover property (@(posedge ref_clk) disable iff (rst) wr_valid_q && wr_space_q);
  c_memory_write: cover property (@(posedge ref_clk) disable iff (rst) wr_valid_q && !wr_space_q);
endmodule

// ===== ddrm_params.svh
`ifndef DDRM_PARAMS_SVH
`define DDRM_PARAMS_SVH
// width of one transferred word
`define DDRM_WORD_W 16
// width of one byte lane group
`define DDRM_BYTE_W 8
// byte A carries word bits 15..8
`define DDRM_A_HI 15
`define DDRM_A_LO 8
// byte B carries word bits 7..0
`define DDRM_B_HI 7
`define DDRM_B_LO 0
// depth of the read data fifo
`define DDRM_FIFO_D 4
// phase counter values inside a written word
`define DDRM_PH_A 1'b0
`define DDRM_PH_B 1'b1
`endif

// ===== ddrm_pkg.sv
`include "ddrm_params.svh"
package ddrm_pkg;
  // read serialiser phase
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_A,
    ST_B
  } ddrm_state_t;
  typedef logic [`DDRM_WORD_W-1:0] ddrm_word_t;
  typedef logic [`DDRM_BYTE_W-1:0] ddrm_byte_t;
endpackage

// ===== ddrm_fifo.sv
`timescale 1ns/1ps
// dual clock fifo, gray pointers, registered read data
module ddrm_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic wr_clk,
  input wire logic rd_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic out_valid
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D]; // storage, needs no reset
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] rg_s1_q, rg_s2_q; // read pointer seen by writer
  logic [AW:0] wg_s1_q, wg_s2_q; // write pointer seen by reader
  logic [AW:0] wbin_d, wgray_d, rbin_d, rgray_d;
  logic push, pop, empty;

  // write side: ready is a flop so it can leave the block directly
  assign push = in_valid & in_ready;
  assign wbin_d = wbin_q + {{AW{1'b0}}, push};
  assign wgray_d = (wbin_d >> 1) ^ wbin_d;
  always_ff @(posedge wr_clk or posedge rst) begin
    if (rst) begin
      wbin_q <= '0;
      wgray_q <= '0;
      in_ready <= 1'b0;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      // full when the next pointer laps the synced read pointer
      in_ready <= (wgray_d != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
    end
  end
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= in_data;
    end
  end
  // read pointer into write domain, two flops
  always_ff @(posedge wr_clk or posedge rst) begin
    if (rst) begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end
  // write pointer into read domain, two flops
  always_ff @(posedge rd_clk or posedge rst) begin
    if (rst) begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
  // read side: refill the output register when it is free or taken
  assign empty = (rgray_q == wg_s2_q);
  assign pop = ~empty & (~out_valid | out_ready);
  assign rbin_d = rbin_q + {{AW{1'b0}}, pop};
  assign rgray_d = (rbin_d >> 1) ^ rbin_d;
  always_ff @(posedge rd_clk or posedge rst) begin
    if (rst) begin
      rbin_q <= '0;
      rgray_q <= '0;
      out_valid <= 1'b0;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      out_valid <= pop | (out_valid & ~out_ready);
    end
  end
  always_ff @(posedge rd_clk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
    end else if (pop) begin
      out_data <= mem_q[rbin_q[AW-1:0]];
    end
  end
endmodule

// ===== ddrm_host_model.sv
`timescale 1ns/1ps
// host side of the link: makes the link clock inside frames and in idle runs with nobody selected
module ddrm_host_model (
  output logic link_clk,
  output logic sel_n,
  output logic read_cycle,
  output logic space_select_bit,
  output ddrm_pkg::ddrm_byte_t dq_i
);
  import ddrm_pkg::*;
  // idle bus: deselected, clock parked low
  initial begin
    link_clk = 1'b0;
    sel_n = 1'b1;
    read_cycle = 1'b0;
    space_select_bit = 1'b0;
    dq_i = 8'h5a;
  end
  // one link phase; the clock always comes back low
  task automatic pulse();
    #16 link_clk = 1'b1;
    #16 link_clk = 1'b0;
  endtask
  // edges with nobody selected, lets reset release reach the link side
  task automatic idle(input int n);
    repeat (n) pulse();
  endtask
  // one written word, first byte A then byte B, byte bit n on lane n
  task automatic write_word(input logic space, input ddrm_byte_t a, input ddrm_byte_t b);
    sel_n = 1'b0;
    read_cycle = 1'b0;
    space_select_bit = space;
    dq_i = a;
    pulse();
    dq_i = b;
    pulse();
    sel_n = 1'b1;
    // released lanes must not keep showing the last byte
    dq_i = ~b;
    // the write crossing loses words closer than 150 ns
    #300;
  endtask
  // read frame of n phases; host lanes keep changing so a stale byte is seen
  task automatic read_frame(input logic space, input int n);
    sel_n = 1'b0;
    read_cycle = 1'b1;
    space_select_bit = space;
    repeat (n) begin
      dq_i = ~dq_i;
      pulse();
    end
    sel_n = 1'b1;
    read_cycle = 1'b0;
    #100;
  endtask
endmodule

// ===== tb_ddrm_lane_mapper.sv
`timescale 1ns/1ps
module tb_ddrm_lane_mapper;
  import ddrm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_valid = 1'b0;
  ddrm_word_t rd_word = 16'h0000;
  ddrm_word_t wr_word_q;
  ddrm_byte_t dq_o, host_dq, dq_wire, byte_a;
  wire logic rd_ready, wr_space_q, wr_valid_q, link_read_q, link_space_q, dq_oe;
  wire logic strobe_o, strobe_oe, strobe_wire, link_clk, sel_n, read_cycle, space_bit;
  logic [7:0] lfsr_q = 8'h52; // random source, fixed start
  logic [16:0] exp_wr[$]; // {space, word} per written word
  ddrm_word_t exp_rd[$]; // words expected on the lanes
  logic have_a = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  // resolved lanes: device wins while it drives, otherwise the host
  assign dq_wire = (dq_oe === 1'b1) ? dq_o : host_dq;
  assign strobe_wire = (strobe_oe === 1'b1) ? strobe_o : 1'b0;
  always #25 ref_clk = ~ref_clk;
  ddrm_host_model u_host (.link_clk(link_clk), .sel_n(sel_n), .read_cycle(read_cycle),
    .space_select_bit(space_bit), .dq_i(host_dq));
  ddrm_lane_mapper u_dut (.ref_clk(ref_clk), .rst(rst), .rd_word(rd_word), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .wr_word_q(wr_word_q), .wr_space_q(wr_space_q), .wr_valid_q(wr_valid_q),
    .link_read_q(link_read_q), .link_space_q(link_space_q), .link_clk(link_clk), .sel_n(sel_n),
    .read_cycle(read_cycle), .space_select_bit(space_bit), .dq_i(dq_wire), .dq_o(dq_o), .dq_oe(dq_oe),
    .read_write_data_strobe_i(strobe_wire), .read_write_data_strobe_o(strobe_o),
    .read_write_data_strobe_oe(strobe_oe));
  // one comparison, counted; unknowns never match
  task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // shift register step for the random words
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic rand_word(output ddrm_word_t w);
    lfsr_q = lfsr_next(lfsr_q);
    w[15:8] = lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    w[7:0] = lfsr_q;
  endtask
  // offer words until refused; rd_ready seen at the falling edge holds at the next rising one
  task automatic fill(input int max, output int cnt);
    ddrm_word_t w;
    cnt = 0;
    @(negedge ref_clk);
    while (rd_ready === 1'b1 && cnt < max) begin
      rand_word(w);
      rd_word = w;
      rd_valid = 1'b1;
      exp_rd.push_back(w);
      cnt++;
      @(negedge ref_clk);
    end
    rd_valid = 1'b0;
  endtask
  // written words come out as one pulse; sampled away from the launching edge
  always @(negedge ref_clk) begin
    if (wr_valid_q === 1'b1) begin
      check("write word", (exp_wr.size() > 0) ? exp_wr.pop_front() : 17'h1_ffff, {wr_space_q, wr_word_q});
    end
  end
  // read lanes: byte A with strobe high, byte B on the very next phase with strobe low
  always @(negedge link_clk) begin
    if (dq_oe === 1'b1 && strobe_o === 1'b1) begin
      if (have_a) check("second strobe high", 17'h0_0000, 17'h0_0001);
      byte_a = dq_o;
      have_a = 1'b1;
    end else if (have_a) begin
      have_a = 1'b0;
      check("read word", (exp_rd.size() > 0) ? {1'b0, exp_rd.pop_front()} : 17'h1_ffff, {1'b0, byte_a, dq_o});
    end
  end
  // watchdog: the whole sequence needs well under 20 us
  initial begin
    #20000;
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    int cnt;
    ddrm_word_t w;
    logic sp;
    ddrm_byte_t a, b;
    // reset spans both clocks, three core cycles
    fork
      u_host.idle(4);
      repeat (3) @(negedge ref_clk);
    join
    rst = 1'b0;
    u_host.idle(3);
    repeat (2) @(negedge ref_clk);
    // writes alternate spaces; memory space stored as the host placed it
    for (int i = 0; i < 6; i++) begin
      rand_word(w);
      sp = i[0];
      a = sp ? w[15:8] : w[7:0];
      b = sp ? w[7:0] : w[15:8];
      exp_wr.push_back({sp, a, b});
      u_host.write_word(sp, a, b);
    end
    check("writes left", 17'h0_0000, 17'(exp_wr.size()));
    // fill the read buffer until it refuses, nothing is read meanwhile
    fill(10, cnt);
    check("fifo depth", 17'h0_0001, 17'(cnt >= `DDRM_FIFO_D && cnt <= `DDRM_FIFO_D + 1));
    // link levels reach the core while the frame runs
    fork
      u_host.read_frame(1'b1, 28);
      begin
        repeat (8) @(negedge ref_clk);
        check("reg frame levels", 17'h0_0007, {14'h0000, link_read_q, link_space_q, strobe_oe});
      end
    join
    check("reg reads left", 17'h0_0000, 17'(exp_rd.size()));
    fill(2, cnt);
    check("second fill", 17'h0_0002, 17'(cnt));
    fork
      u_host.read_frame(1'b0, 16);
      begin
        repeat (6) @(negedge ref_clk);
        check("mem frame levels", 17'h0_0005, {14'h0000, link_read_q, link_space_q, strobe_oe});
      end
    join
    check("mem reads left", 17'h0_0000, 17'(exp_rd.size()));
    // clock parked: enables must still drop, read level needs two core edges
    repeat (2) @(negedge ref_clk);
    check("lanes released", 17'h0_0000, {14'h0000, dq_oe, strobe_oe, link_read_q});
    finish_test();
  end
endmodule
